// ---- rtl/scm_ctrl.sv ----
// Behaviour
// R1: Control bit 0 runs host-commanded conversions; 1 starts touch scans on pen touch.
// R2: Software writes zero to the reserved bit below the control bit.
// R3: Mode field zero: no scan and no measurement.
// R4: Mode 0001 repeatedly converts X then Y as a pair.
// R5: Mode 0010 converts X, Y, then both pressure plates each pass.
// R6: Pair and pressure scans keep running, even host-controlled, until pen lift or stop.
// R7: Mode 0011 is an X-only scan, self-controlled only, until lift or stop.
// R8: Mode 0100 is a Y-only scan, self-controlled only, until lift or stop.
// R9: Mode 0101 scans both pressure plates, self-controlled only, until lift or stop.
// R10: Mode 0110 measures the battery voltage.
// R11: Mode 0111 measures extra input two; 1000 measures extra input one.
// R12: Mode 1001 auto-scans extra one, extra two, battery, skipping disabled inputs.
// R13: Auto sequence repeats until stop is written or the mode field changes.
// R14: Mode 1010 measures thermal source one.
// R15: Mode 1011 port-scans extra one, extra two and battery once.
// R16: Mode 1100 measures thermal source two.
// R17: Software never writes mode codes above 1100.
// R18: Interrupt select 00 puts pen touch on the pin, active low.
// R19: Interrupt select 01 puts result ready on the pin, active low.
// R20: Interrupt select 10 puts pen or result ready on the pin, active high.
// R21: Stop bit halts conversion and powers the converter down; clearing resumes (the code resumes only self-controlled touch scans; stop drops host commands).
// R22: Result ready sets when a full result set exists, clears on result read.
// R23: A mode change aborts the running sequence and restarts from the first step.
`timescale 1ns/1ns
`default_nettype none
`include "scm_params.svh"

module scm_ctrl #(
    parameter int DATA_W = 12,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Converter front end
    output scm_pkg::scm_conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    output logic adc_power_down,
    // Touch panel
    input wire logic pen_down,
    // Multipurpose pins
    output logic multipurpose_pin_one,
    output logic multipurpose_pin_two
);
    import scm_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    generate
        if (DATA_W < 1 || DATA_W > 16 || ADDR_W < 4) begin : g_bad_param
            $error("scm_ctrl: DATA_W must be 1..16 and ADDR_W at least 4");
        end
    endgenerate

    // ----------------------------------------
    // Sequence decode
    // ----------------------------------------
    function automatic logic is_touch(input logic [3:0] md);
        return (md >= `SCM_MD_XY) && (md <= `SCM_MD_Z);
    endfunction

    function automatic logic self_only(input logic [3:0] md);
        return (md >= `SCM_MD_X) && (md <= `SCM_MD_Z);
    endfunction

    function automatic logic repeats(input logic [3:0] md);
        return is_touch(md) || (md == `SCM_MD_AUTO);
    endfunction

    function automatic logic [3:0] seq_mask(input logic [3:0] md, input logic [3:0] en);
        logic [3:0] m;
        m = 4'h0;
        case (md)
            `SCM_MD_XY, `SCM_MD_Z: m = 4'h3;
            `SCM_MD_XYZ: m = 4'hf;
            `SCM_MD_AUTO: m = {1'b0, en[`SCM_EN_VBAT], en[`SCM_EN_EXT2], en[`SCM_EN_EXT1]};
            `SCM_MD_PORT: m = 4'h7;
            `SCM_MD_NONE: m = 4'h0;
            default: m = (md > `SCM_MD_TH2) ? 4'h0 : 4'h1;
        endcase
        return m;
    endfunction

    function automatic scm_chan_t seq_chan(input logic [3:0] md, input logic [1:0] idx);
        scm_chan_t c;
        c = CH_NONE;
        case (md)
            `SCM_MD_XY, `SCM_MD_XYZ: begin
                case (idx)
                    2'h0: c = CH_X;
                    2'h1: c = CH_Y;
                    2'h2: c = CH_PRESSURE_PLATE_A;
                    default: c = CH_PRESSURE_PLATE_B;
                endcase
            end
            `SCM_MD_X: c = CH_X;
            `SCM_MD_Y: c = CH_Y;
            `SCM_MD_Z: c = (idx == 2'h0) ? CH_PRESSURE_PLATE_A : CH_PRESSURE_PLATE_B;
            `SCM_MD_VBAT: c = CH_VBAT;
            `SCM_MD_EXT2: c = CH_EXTRA_INPUT_TWO;
            `SCM_MD_EXT1: c = CH_EXTRA_INPUT_ONE;
            `SCM_MD_AUTO, `SCM_MD_PORT: begin
                case (idx)
                    2'h0: c = CH_EXTRA_INPUT_ONE;
                    2'h1: c = CH_EXTRA_INPUT_TWO;
                    default: c = CH_VBAT;
                endcase
            end
            `SCM_MD_TH1: c = CH_THERMAL_SENSE_ONE;
            `SCM_MD_TH2: c = CH_THERMAL_SENSE_TWO;
            default: c = CH_NONE;
        endcase
        return c;
    endfunction

    // First enabled step at or after from; 4 means none
    function automatic logic [2:0] next_from(input logic [3:0] mask, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= from)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    scm_mode_ctrl_t mode_q, mode_d;
    logic stop_q, stop_d;
    logic [3:0] ena_q, ena_d;
    logic cmd_q, cmd_d;
    logic ready_q, ready_d;
    logic [7:0] rdata_d;
    logic pin1_d, pin2_d;
    logic mode_chg;
    scm_state_t state_q, state_d;
    logic [1:0] idx_q, idx_d;
    scm_conv_req_t req_d;
    logic [DATA_W-1:0] res_q [`SCM_RES_SLOTS];
    logic [DATA_W-1:0] res_d [`SCM_RES_SLOTS];
    logic pass_done;
    logic take_cmd;
    logic abort;
    logic start_ok;
    logic [3:0] mask;
    logic [2:0] nx;
    logic [ADDR_W-1:0] res_off;
    logic res_hit;
    logic irq_lvl;
    logic [15:0] res_word;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    assign res_off = reg_addr - ADDR_W'(`SCM_OFS_RES0);
    assign res_hit = (reg_addr >= ADDR_W'(`SCM_OFS_RES0)) && (res_off < ADDR_W'(`SCM_RES_BYTES));
    assign res_word = 16'(res_q[res_off[2:1]]);

    always_comb begin
        mode_d = mode_q;
        stop_d = stop_q;
        ena_d = ena_q;
        cmd_d = cmd_q;
        ready_d = ready_q;
        rdata_d = 8'h00;
        mode_chg = 1'b0;
        irq_lvl = 1'b1;
        if (take_cmd || stop_q) begin
            cmd_d = 1'b0;
        end
        if (reg_wr) begin
            if (reg_addr == ADDR_W'(`SCM_OFS_MODE)) begin
                mode_d = scm_mode_ctrl_t'(reg_wdata);
                mode_chg = (mode_d.mode != mode_q.mode); // R23
                cmd_d = (mode_d.mode != `SCM_MD_NONE); // R1
            end else if (reg_addr == ADDR_W'(`SCM_OFS_CONV)) begin
                stop_d = reg_wdata[`SCM_STOP_BIT]; // R21
            end else if (reg_addr == ADDR_W'(`SCM_OFS_ENA)) begin
                ena_d = reg_wdata[3:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == ADDR_W'(`SCM_OFS_MODE)) begin
                rdata_d = mode_q;
            end else if (reg_addr == ADDR_W'(`SCM_OFS_CONV)) begin
                rdata_d = {stop_q, 7'h00};
            end else if (reg_addr == ADDR_W'(`SCM_OFS_ENA)) begin
                rdata_d = {4'h0, ena_q};
            end else if (reg_addr == ADDR_W'(`SCM_OFS_STAT)) begin
                rdata_d = scm_status_t'{busy: (state_q == ST_WAIT), ready: ready_q, pen: pen_down,
                                        pend: cmd_q, rsvd: 2'h0, step: idx_q};
            end else if (res_hit) begin
                rdata_d = res_off[0] ? res_word[15:8] : res_word[7:0];
                ready_d = 1'b0; // R22
            end
        end
        if (pass_done) begin
            ready_d = 1'b1; // R22
        end
        case (mode_q.irq_sel)
            `SCM_IRQ_PEN: irq_lvl = ~pen_down; // R18
            `SCM_IRQ_RDY: irq_lvl = ~ready_q; // R19
            `SCM_IRQ_BOTH: irq_lvl = pen_down | ready_q; // R20
            default: irq_lvl = 1'b1;
        endcase
        pin1_d = ena_q[`SCM_EN_ROUTE] ? 1'b1 : irq_lvl;
        pin2_d = ena_q[`SCM_EN_ROUTE] ? irq_lvl : 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= scm_mode_ctrl_t'(`SCM_RST_MODE);
            stop_q <= `SCM_RST_STOP;
            ena_q <= `SCM_RST_ENA;
            cmd_q <= 1'b0;
            ready_q <= 1'b0;
            reg_rdata <= 8'h00;
            adc_power_down <= `SCM_RST_STOP;
            multipurpose_pin_one <= 1'b1;
            multipurpose_pin_two <= 1'b1;
        end else begin
            mode_q <= mode_d;
            stop_q <= stop_d;
            ena_q <= ena_d;
            cmd_q <= cmd_d;
            ready_q <= ready_d;
            reg_rdata <= rdata_d;
            adc_power_down <= stop_d;
            multipurpose_pin_one <= pin1_d;
            multipurpose_pin_two <= pin2_d;
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    assign abort = stop_q || mode_chg || (is_touch(mode_q.mode) && !pen_down)
                   || (self_only(mode_d.mode) && !mode_d.self_ctl); // R6 R7 R8 R9 R21 R23
    assign start_ok = is_touch(mode_q.mode)
                      ? (pen_down && (mode_q.self_ctl || (cmd_q && !self_only(mode_q.mode)))) // R1
                      : (cmd_q && (mode_q.mode != `SCM_MD_NONE)); // R3
    assign mask = seq_mask(mode_q.mode, ena_d); // R12

    always_comb begin
        nx = 3'h4;
        state_d = state_q;
        idx_d = idx_q;
        req_d = '{start: 1'b0, chan: conv_req.chan};
        res_d = res_q;
        pass_done = 1'b0;
        take_cmd = 1'b0;
        case (state_q)
            ST_IDLE: begin
                take_cmd = 1'b1;
                if (!abort && start_ok) begin
                    nx = next_from(mask, 3'h0);
                end
            end
            ST_WAIT: begin
                if (abort) begin
                    state_d = ST_IDLE;
                end else if (conv_done) begin
                    res_d[idx_q] = conv_data;
                    nx = next_from(mask, {1'b0, idx_q} + 3'h1); // R12
                    if (nx == 3'h4) begin
                        pass_done = 1'b1;
                        if (repeats(mode_q.mode)) begin
                            nx = next_from(mask, 3'h0); // R4 R6 R13
                        end else begin
                            state_d = ST_IDLE; // R10 R14 R15 R16
                        end
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (nx != 3'h4) begin
            state_d = ST_WAIT;
            idx_d = nx[1:0];
            req_d.start = 1'b1;
            req_d.chan = seq_chan(mode_q.mode, nx[1:0]); // R4 R5 R11
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            idx_q <= 2'h0;
            conv_req <= '{start: 1'b0, chan: CH_NONE};
            for (int i = 0; i < `SCM_RES_SLOTS; i++) begin
                res_q[i] <= '0;
            end
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            conv_req <= req_d;
            res_q <= res_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    scm_chan_t last_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= CH_NONE;
        end else if (conv_req.start) begin
            last_q <= conv_req.chan;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_host_no_self: assert property (!mode_q.self_ctl && self_only(mode_q.mode) |-> !conv_req.start) // R1
        else $error("self-only scan started in host mode");
    a_no_scan_idle: assert property (mode_q.mode == `SCM_MD_NONE |-> !conv_req.start) // R3
        else $error("conversion started with mode field zero");
    a_pair_chans: assert property (conv_req.start && mode_q.mode == `SCM_MD_XY
                                   |-> conv_req.chan inside {CH_X, CH_Y}) // R4
        else $error("pair scan issued wrong channel");
    a_press_order: assert property (conv_req.start && mode_q.mode == `SCM_MD_XYZ
                                    && conv_req.chan == CH_PRESSURE_PLATE_B
                                    |-> last_q == CH_PRESSURE_PLATE_A) // R5
        else $error("pressure plate b not after plate a");
    a_touch_repeat: assert property (pass_done && is_touch(mode_q.mode) |=> conv_req.start) // R6
        else $error("touch scan did not continue");
    a_single_chan: assert property (conv_req.start && mode_q.mode inside {`SCM_MD_X, `SCM_MD_Y}
                                    |-> mode_q.self_ctl && conv_req.chan
                                    == (mode_q.mode == `SCM_MD_X ? CH_X : CH_Y)) // R7
        else $error("single axis scan wrong channel or mode");
    a_plates_only: assert property (conv_req.start && mode_q.mode == `SCM_MD_Z
                                    |-> conv_req.chan inside {CH_PRESSURE_PLATE_A, CH_PRESSURE_PLATE_B}) // R9
        else $error("plate scan issued wrong channel");
    a_meas_chan: assert property (conv_req.start && mode_q.mode inside {`SCM_MD_VBAT, `SCM_MD_TH1, `SCM_MD_TH2}
                                  |-> conv_req.chan == (mode_q.mode == `SCM_MD_VBAT ? CH_VBAT
                                  : mode_q.mode == `SCM_MD_TH1 ? CH_THERMAL_SENSE_ONE
                                  : CH_THERMAL_SENSE_TWO)) // R10
        else $error("measurement issued wrong channel");
    a_auto_skip: assert property (conv_req.start && mode_q.mode == `SCM_MD_AUTO
                                  |-> (conv_req.chan != CH_EXTRA_INPUT_ONE || ena_q[`SCM_EN_EXT1])
                                  && (conv_req.chan != CH_EXTRA_INPUT_TWO || ena_q[`SCM_EN_EXT2])
                                  && (conv_req.chan != CH_VBAT || ena_q[`SCM_EN_VBAT])) // R12
        else $error("auto scan converted a disabled input");
    a_auto_repeat: assert property (pass_done && mode_q.mode == `SCM_MD_AUTO |=> conv_req.start) // R13
        else $error("auto scan did not repeat");
    a_port_once: assert property (pass_done && mode_q.mode == `SCM_MD_PORT
                                  |=> state_q == ST_IDLE && !conv_req.start) // R15
        else $error("port scan did not stop after one pass");
    a_pin_pen: assert property (mode_q.irq_sel == `SCM_IRQ_PEN && !ena_q[`SCM_EN_ROUTE]
                                |=> multipurpose_pin_one == !$past(pen_down)) // R18
        else $error("pin one not active-low pen touch");
    a_pin_ready: assert property (mode_q.irq_sel == `SCM_IRQ_RDY && ena_q[`SCM_EN_ROUTE]
                                  |=> multipurpose_pin_two == !$past(ready_q)) // R19
        else $error("pin two not active-low result ready");
    a_pin_both: assert property (mode_q.irq_sel == `SCM_IRQ_BOTH && !ena_q[`SCM_EN_ROUTE]
                                 |=> multipurpose_pin_one == ($past(pen_down) || $past(ready_q))) // R20
        else $error("pin one not combined active-high");
    a_stop_halts: assert property (stop_q |=> !conv_req.start && state_q == ST_IDLE && adc_power_down == stop_q) // R21
        else $error("stop did not halt and power down");
    a_ready_set: assert property (pass_done |=> ready_q ##1 (ready_q || $past(reg_rd))) // R22
        else $error("result ready not set after pass");
    a_mode_abort: assert property (mode_chg |=> state_q == ST_IDLE && !conv_req.start) // R23
        else $error("mode change did not abort sequence");

    c_press_pass: cover property (pass_done && mode_q.mode == `SCM_MD_XYZ);
    c_auto_skip: cover property (pass_done && mode_q.mode == `SCM_MD_AUTO && !ena_q[`SCM_EN_EXT2]);
    c_stop_busy: cover property (stop_q && state_q == ST_WAIT);
    c_mode_swap: cover property (mode_chg && state_q == ST_WAIT);

endmodule

`default_nettype wire

// ---- rtl/scm_params.svh ----
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCM_OFS_MODE 8'h00
`define SCM_OFS_CONV 8'h01
`define SCM_OFS_ENA 8'h02
`define SCM_OFS_STAT 8'h03
`define SCM_OFS_RES0 8'h04
`define SCM_RES_BYTES 8'h08
`define SCM_RES_SLOTS 4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCM_STOP_BIT 7
`define SCM_EN_EXT1 0
`define SCM_EN_EXT2 1
`define SCM_EN_VBAT 2
`define SCM_EN_ROUTE 3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCM_RST_MODE 8'h00
`define SCM_RST_STOP 1'b0
`define SCM_RST_ENA 4'h7
// ----------------------------------------
// Conversion mode codes
// ----------------------------------------
`define SCM_MD_NONE 4'h0
`define SCM_MD_XY 4'h1
`define SCM_MD_XYZ 4'h2
`define SCM_MD_X 4'h3
`define SCM_MD_Y 4'h4
`define SCM_MD_Z 4'h5
`define SCM_MD_VBAT 4'h6
`define SCM_MD_EXT2 4'h7
`define SCM_MD_EXT1 4'h8
`define SCM_MD_AUTO 4'h9
`define SCM_MD_TH1 4'ha
`define SCM_MD_PORT 4'hb
`define SCM_MD_TH2 4'hc
// ----------------------------------------
// Interrupt pin selections
// ----------------------------------------
`define SCM_IRQ_PEN 2'h0
`define SCM_IRQ_RDY 2'h1
`define SCM_IRQ_BOTH 2'h2
`endif

// ---- rtl/scm_pkg.sv ----
package scm_pkg;
    typedef enum logic [3:0] {
        CH_NONE, CH_X, CH_Y, CH_PRESSURE_PLATE_A, CH_PRESSURE_PLATE_B, CH_VBAT,
        CH_EXTRA_INPUT_ONE, CH_EXTRA_INPUT_TWO, CH_THERMAL_SENSE_ONE, CH_THERMAL_SENSE_TWO
    } scm_chan_t;
    typedef enum logic {ST_IDLE, ST_WAIT} scm_state_t;
    typedef struct packed {
        logic self_ctl;
        logic rsvd;
        logic [3:0] mode;
        logic [1:0] irq_sel;
    } scm_mode_ctrl_t;
    typedef struct packed {
        logic start;
        scm_chan_t chan;
    } scm_conv_req_t;
    typedef struct packed {
        logic busy;
        logic ready;
        logic pen;
        logic pend;
        logic [1:0] rsvd;
        logic [1:0] step;
    } scm_status_t;
endpackage

// ---- sim/scm_conv_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module scm_conv_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request and answer
    input wire scm_pkg::scm_conv_req_t conv_req,
    input wire logic [7:0] lat,
    output logic conv_done = 1'b0,
    output logic [11:0] conv_data = 12'h000
);
    import scm_pkg::*;
    // ----------------------------------------
    // Converter with programmable latency
    // ----------------------------------------
    logic busy = 1'b0;
    logic [7:0] cnt = 8'h00;
    scm_chan_t ch = CH_NONE;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // Data bus not held outside the done pulse
            conv_data <= ~conv_data;
            if (conv_req.start) begin
                busy <= 1'b1;
                cnt <= lat;
                ch <= conv_req.chan;
            end else if (busy && cnt <= 8'h01) begin
                busy <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {ch, 8'h3c};
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb_sar_conversion_mode_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_sar_conversion_mode_control;
    import scm_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, conv_done, pen_down, pin_one, pin_two, pdn;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lat, d;
    logic [11:0] conv_data;
    scm_conv_req_t conv_req;
    int errors, total_checks, nst;
    logic [3:0] mcode [5] = '{4'h6, 4'h7, 4'h8, 4'ha, 4'hc};
    scm_chan_t mchan [5] = '{CH_VBAT, CH_EXTRA_INPUT_TWO, CH_EXTRA_INPUT_ONE, CH_THERMAL_SENSE_ONE,
        CH_THERMAL_SENSE_TWO};
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    scm_ctrl uut(.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_req(conv_req),
        .conv_done(conv_done), .conv_data(conv_data), .adc_power_down(pdn), .pen_down(pen_down),
        .multipurpose_pin_one(pin_one), .multipurpose_pin_two(pin_two));
    scm_conv_model conv(.ref_clk(ref_clk), .rst_n(rst_n), .conv_req(conv_req), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));
    always @(posedge ref_clk) begin
        if (conv_req.start === 1'b1)
            nst++;
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a, d);
        chk(d & m, e);
    endtask
    task automatic wst(input scm_chan_t c);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (conv_req.start !== 1'b1 && n < 100);
        chk({3'h0, conv_req}, {4'h1, c});
    endtask
    task automatic nost(input int n);
        int s;
        @(posedge ref_clk);
        #1;
        s = nst;
        repeat (n) @(posedge ref_clk);
        #1;
        chk(8'(nst - s), 8'h00);
    endtask
    task automatic pins(input logic e1, input logic e2);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({6'h0, pin_two, pin_one}, {6'h0, e2, e1});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pen_down = 1'b0;
        lat = 8'h01;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(8'h00, 8'hff, 8'h00);
        rdc(8'h01, 8'hff, 8'h00);
        rdc(8'h02, 8'hff, 8'h07);
        wr(8'h3f, 8'h55);
        rdc(8'h3f, 8'hff, 8'h00);
        wr(8'h03, 8'hff);
        rdc(8'h03, 8'hff, 8'h00);
        pins(1'b1, 1'b1);
        nost(20);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, {2'b00, mcode[i], 2'b11});
            wst(mchan[i]);
            nost(20);
        end
        $display("test measurements done");
        lat <= 8'h05;
        pen_down <= 1'b1;
        wr(8'h00, 8'h88);
        wst(CH_X);
        wst(CH_Y);
        wst(CH_PRESSURE_PLATE_A);
        wst(CH_PRESSURE_PLATE_B);
        wst(CH_X);
        @(posedge ref_clk);
        pen_down <= 1'b0;
        nost(40);
        rdc(8'h03, 8'h40, 8'h40);
        rdc(8'h04, 8'hff, 8'h3c);
        rdc(8'h05, 8'hff, 8'h01);
        rdc(8'h0b, 8'hff, 8'h04);
        rdc(8'h03, 8'h40, 8'h00);
        $display("test pressure scan done");
        @(posedge ref_clk);
        pen_down <= 1'b1;
        for (int i = 3; i < 6; i++) begin
            wr(8'h00, {2'b00, 4'(i), 2'b00});
            nost(20);
        end
        wr(8'h00, 8'h8c);
        wst(CH_X);
        wst(CH_X);
        wr(8'h00, 8'h90);
        wst(CH_Y);
        wr(8'h00, 8'h94);
        wst(CH_PRESSURE_PLATE_A);
        wst(CH_PRESSURE_PLATE_B);
        wst(CH_PRESSURE_PLATE_A);
        wr(8'h00, 8'h04);
        wst(CH_X);
        wst(CH_Y);
        wst(CH_X);
        wr(8'h01, 8'h80);
        #1;
        chk({7'h0, pdn}, 8'h01);
        rdc(8'h01, 8'h80, 8'h80);
        nost(30);
        wr(8'h01, 8'h00);
        #1;
        chk({7'h0, pdn}, 8'h00);
        $display("test touch scans done");
        lat <= 8'h01;
        pen_down <= 1'b0;
        wr(8'h02, 8'h05);
        wr(8'h00, 8'h24);
        wst(CH_EXTRA_INPUT_ONE);
        wst(CH_VBAT);
        wst(CH_EXTRA_INPUT_ONE);
        wst(CH_VBAT);
        wr(8'h00, 8'h2c);
        wst(CH_EXTRA_INPUT_ONE);
        wst(CH_EXTRA_INPUT_TWO);
        wst(CH_VBAT);
        nost(30);
        wr(8'h00, 8'h24);
        wst(CH_EXTRA_INPUT_ONE);
        wr(8'h01, 8'h80);
        nost(30);
        wr(8'h01, 8'h00);
        $display("test auto scan done");
        wr(8'h02, 8'h07);
        wr(8'h00, 8'h00);
        pen_down <= 1'b1;
        pins(1'b0, 1'b1);
        wr(8'h00, 8'h01);
        rd(8'h04, d);
        pins(1'b1, 1'b1);
        wr(8'h00, 8'h19);
        wst(CH_VBAT);
        pins(1'b0, 1'b1);
        wr(8'h00, 8'h02);
        pins(1'b1, 1'b1);
        rd(8'h04, d);
        @(posedge ref_clk);
        pen_down <= 1'b0;
        pins(1'b0, 1'b1);
        wr(8'h02, 8'h0f);
        pins(1'b1, 1'b0);
        wr(8'h00, 8'h19);
        wst(CH_VBAT);
        pins(1'b1, 1'b0);
        $display("test interrupt pin done");
        stop_test();
    end
endmodule
`default_nettype wire
